// file: rtl/ped_top.sv
`timescale 1ns/1ps
// Function
// (RL1) Edge polarity bit 1 selects falling edges, 0 selects rising edges, per pin.
// (RL2) A pin's event flag sets on its selected edge only while its enable bit is 1.
// (RL3) A set flag raises its port's request line at once, one line per port.
// (RL4) Sixteen event flags exist, eight per port, each tied to the same pin index.
// (RL5) Writing 1 clears a flag, writing 0 leaves it, reads return the flag.
// (RL6) All event flags read 0 after reset.
// (RL7) Software treats the port requests as level triggered and clears flags in the handler.
// (RL8) Software clears stale flags before enabling pin interrupts.
// (RL9) Debounce exists on port 0 only, bits 6..4 for pins 7..4 and bits 2..0 for pins 3..0.
// (RL10) Selector 0 bypasses the filter, values 1..7 give 256 to 16384 cycles.
// (RL11) Pulses up to the check time are rejected, levels held twice it are accepted.
// (RL12) With the clock stopped an active filter blocks events, so software disables it first.
// (RL13) Software disables port 0 interrupts before changing the debounce settings.
// (RL14) Transitions on a pin whose enable bit is 0 are ignored.
// (RL15) Pin inputs are registered before debounce and edge detection.
// (RL16) An edge in the same cycle as a write-1 clear leaves the flag set.
module ped_top #(
  parameter int PIN_W = 8
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic [PIN_W-1:0] port0_pins,
  input  wire logic [PIN_W-1:0] port1_pins,
  input  wire logic [15:0]      reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [7:0]       reg_rdata,
  output logic                  port0_irq,
  output logic                  port1_irq,
  output logic                  irq
);

  initial begin
    if (PIN_W != 8) begin
      $error("ped_top supports only 8-bit ports");
    end
  end

  logic [PIN_W-1:0] p0_samp_r;
  logic [PIN_W-1:0] p1_samp_r;
  logic [PIN_W-1:0] p0_filt;
  logic [PIN_W-1:0] p0_prev_r;
  logic [PIN_W-1:0] p1_prev_r;
  logic [PIN_W-1:0] p0_ie_r;
  logic [PIN_W-1:0] p1_ie_r;
  logic [PIN_W-1:0] p0_edge_r;
  logic [PIN_W-1:0] p1_edge_r;
  logic [PIN_W-1:0] p0_flag_r;
  logic [PIN_W-1:0] p1_flag_r;
  logic [PIN_W-1:0] p0_flag_nxt;
  logic [PIN_W-1:0] p1_flag_nxt;
  logic [PIN_W-1:0] p0_hit;
  logic [PIN_W-1:0] p1_hit;
  logic [7:0]       deb_ctl_r;
  logic [1:0]       irq_mask_r;
  logic [1:0]       irq_stat_r;
  logic [1:0]       irq_stat_nxt;
  logic [1:0]       port_rise;
  logic             p0_req_d_r;
  logic             p1_req_d_r;
  logic [7:0]       rdata_nxt;

  // Register decode used by both the write and the read paths.
  function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
    hit = (a == b);
  endfunction

  // Selected-edge detector for one port.
  function automatic logic [PIN_W-1:0] edge_hit(input logic [PIN_W-1:0] cur,
                                                input logic [PIN_W-1:0] prev,
                                                input logic [PIN_W-1:0] pol,
                                                input logic [PIN_W-1:0] ena);
    logic [PIN_W-1:0] rise;
    logic [PIN_W-1:0] fall;
    rise     = cur & ~prev;
    fall     = ~cur & prev;
    edge_hit = ((pol & fall) | (~pol & rise)) & ena; // RL1
  endfunction

  // Pin inputs are treated as synchronous and registered once.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      p0_samp_r <= '0;
      p1_samp_r <= '0;
    end else begin
      p0_samp_r <= port0_pins; // RL15
      p1_samp_r <= port1_pins; // RL15
    end
  end

  // Port 0 nibble filters.
  ped_debounce #(.WIDTH(4)) u_deb_lo (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .sel      (deb_ctl_r[ped_pkg::DEB_LO_LSB +: ped_pkg::DEB_W]),
    .pin_in   (p0_samp_r[3:0]),
    .pin_out  (p0_filt[3:0])
  ); // RL9

  ped_debounce #(.WIDTH(4)) u_deb_hi (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .sel      (deb_ctl_r[ped_pkg::DEB_HI_LSB +: ped_pkg::DEB_W]),
    .pin_in   (p0_samp_r[7:4]),
    .pin_out  (p0_filt[7:4])
  ); // RL9

  // Previous samples for edge detection.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      p0_prev_r <= '0;
      p1_prev_r <= '0;
    end else begin
      p0_prev_r <= p0_filt;
      p1_prev_r <= p1_samp_r;
    end
  end

  // Edges on disabled pins never reach the flags.
  assign p0_hit = edge_hit(p0_filt, p0_prev_r, p0_edge_r, p0_ie_r);   // RL2 RL14
  assign p1_hit = edge_hit(p1_samp_r, p1_prev_r, p1_edge_r, p1_ie_r); // RL2 RL14

  // Configuration registers written by software.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      p0_ie_r    <= ped_pkg::RST_BYTE;
      p1_ie_r    <= ped_pkg::RST_BYTE;
      p0_edge_r  <= ped_pkg::RST_BYTE;
      p1_edge_r  <= ped_pkg::RST_BYTE;
      deb_ctl_r  <= ped_pkg::RST_BYTE;
      irq_mask_r <= ped_pkg::RST_PAIR;
    end else if (reg_wr) begin
      if (hit(reg_addr, ped_pkg::ADDR_P0_IE)) begin
        p0_ie_r <= reg_wdata;
      end
      if (hit(reg_addr, ped_pkg::ADDR_P1_IE)) begin
        p1_ie_r <= reg_wdata;
      end
      if (hit(reg_addr, ped_pkg::ADDR_P0_EDGE)) begin
        p0_edge_r <= reg_wdata;
      end
      if (hit(reg_addr, ped_pkg::ADDR_P1_EDGE)) begin
        p1_edge_r <= reg_wdata;
      end
      if (hit(reg_addr, ped_pkg::ADDR_P0_DEB)) begin
        deb_ctl_r <= reg_wdata & ped_pkg::DEB_MASK; // RL9
      end
      if (hit(reg_addr, ped_pkg::ADDR_IRQ_MASK)) begin
        irq_mask_r <= reg_wdata[1:0];
      end
    end
  end

  // Flag next values: write-1 clears, a new event wins over the clear.
  always_comb begin
    p0_flag_nxt = p0_flag_r;
    p1_flag_nxt = p1_flag_r;
    if (reg_wr && hit(reg_addr, ped_pkg::ADDR_P0_FLAGS)) begin
      p0_flag_nxt = p0_flag_r & ~reg_wdata; // RL5
    end
    if (reg_wr && hit(reg_addr, ped_pkg::ADDR_P1_FLAGS)) begin
      p1_flag_nxt = p1_flag_r & ~reg_wdata; // RL5
    end
    p0_flag_nxt = p0_flag_nxt | p0_hit; // RL16
    p1_flag_nxt = p1_flag_nxt | p1_hit; // RL16
  end

  // Sixteen event flags, eight per port.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      p0_flag_r <= ped_pkg::RST_BYTE; // RL6
      p1_flag_r <= ped_pkg::RST_BYTE; // RL6
    end else begin
      p0_flag_r <= p0_flag_nxt; // RL4
      p1_flag_r <= p1_flag_nxt; // RL4
    end
  end

  // Port request lines follow the flags as levels.
  assign port0_irq = |p0_flag_r; // RL3
  assign port1_irq = |p1_flag_r; // RL3

  // Request rising edges set sticky summary status bits.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      p0_req_d_r <= 1'b0;
      p1_req_d_r <= 1'b0;
    end else begin
      p0_req_d_r <= port0_irq;
      p1_req_d_r <= port1_irq;
    end
  end
  assign port_rise = {port1_irq & ~p1_req_d_r, port0_irq & ~p0_req_d_r};

  // Summary status is cleared by writing one; a new event wins.
  always_comb begin
    irq_stat_nxt = irq_stat_r;
    if (reg_wr && hit(reg_addr, ped_pkg::ADDR_IRQ_STAT)) begin
      irq_stat_nxt = irq_stat_r & ~reg_wdata[1:0];
    end
    irq_stat_nxt = irq_stat_nxt | port_rise;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_r <= ped_pkg::RST_PAIR;
    end else begin
      irq_stat_r <= irq_stat_nxt;
    end
  end

  // Combined interrupt is a level while any unmasked status bit is set.
  assign irq = |(irq_stat_r & irq_mask_r);

  // Read mux; unmapped addresses return zero.
  always_comb begin
    rdata_nxt = 8'h00;
    if (hit(reg_addr, ped_pkg::ADDR_P0_IE)) begin
      rdata_nxt = p0_ie_r;
    end else if (hit(reg_addr, ped_pkg::ADDR_P1_IE)) begin
      rdata_nxt = p1_ie_r;
    end else if (hit(reg_addr, ped_pkg::ADDR_P0_EDGE)) begin
      rdata_nxt = p0_edge_r;
    end else if (hit(reg_addr, ped_pkg::ADDR_P1_EDGE)) begin
      rdata_nxt = p1_edge_r;
    end else if (hit(reg_addr, ped_pkg::ADDR_P0_FLAGS)) begin
      rdata_nxt = p0_flag_r; // RL5
    end else if (hit(reg_addr, ped_pkg::ADDR_P1_FLAGS)) begin
      rdata_nxt = p1_flag_r; // RL5
    end else if (hit(reg_addr, ped_pkg::ADDR_P0_DEB)) begin
      rdata_nxt = deb_ctl_r;
    end else if (hit(reg_addr, ped_pkg::ADDR_IRQ_MASK)) begin
      rdata_nxt = {6'h00, irq_mask_r};
    end else if (hit(reg_addr, ped_pkg::ADDR_IRQ_STAT)) begin
      rdata_nxt = {6'h00, irq_stat_r};
    end
  end

  // Read data stand for one cycle after the read strobe, zero otherwise.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

// file: rtl/ped_pkg.sv
package ped_pkg;
  // Register offsets on the plain register port.
  localparam logic [15:0] ADDR_P0_IE    = 16'h5205;
  localparam logic [15:0] ADDR_P0_EDGE  = 16'h5206;
  localparam logic [15:0] ADDR_P0_FLAGS = 16'h5207;
  localparam logic [15:0] ADDR_P0_DEB   = 16'h5208;
  localparam logic [15:0] ADDR_P1_IE    = 16'h5215;
  localparam logic [15:0] ADDR_P1_EDGE  = 16'h5216;
  localparam logic [15:0] ADDR_P1_FLAGS = 16'h5217;
  localparam logic [15:0] ADDR_IRQ_MASK = 16'h5240;
  localparam logic [15:0] ADDR_IRQ_STAT = 16'h5241;

  // Reset values.
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_PAIR = 2'h0;

  // Debounce control field layout.
  localparam int DEB_LO_LSB = 0;
  localparam int DEB_HI_LSB = 4;
  localparam int DEB_W      = 3;
  localparam logic [7:0] DEB_MASK = 8'h77;

  // Shortest check time in clock cycles; each selector step doubles it.
  localparam int CHECK_BASE_CYC = 256;
  localparam int CHECK_MAX_CYC  = 16384;
  localparam int CNT_W          = 15;
endpackage

// file: rtl/ped_debounce.sv
`timescale 1ns/1ps
// Debounce filter for one nibble of pins; selector 0 passes samples through.
module ped_debounce #(
  parameter int WIDTH = 4
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic [2:0]       sel,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out
);

  logic [ped_pkg::CNT_W-1:0] tick_cnt_r;
  logic                      tick;
  logic [WIDTH-1:0]          stage_r;
  logic [WIDTH-1:0]          stable_r;

  // Limit is base cycles shifted by selector minus one, less one, so a tick comes every base << (sel - 1) cycles.
  function automatic logic [ped_pkg::CNT_W-1:0] check_limit(input logic [2:0] s);
    logic [ped_pkg::CNT_W-1:0] base;
    base = ped_pkg::CNT_W'(ped_pkg::CHECK_BASE_CYC);
    check_limit = (s == 3'h0) ? '0 : (base << (s - 3'h1)) - 1'b1;
  endfunction

  // Free running check-time divider producing a one-cycle enable; it only advances
  // on the clock, so a stopped clock freezes the filter and blocks new levels.
  // RL12
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_r <= '0;
    end else if (tick || sel == 3'h0) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
    end
  end
  assign tick = (tick_cnt_r >= check_limit(sel)) && (sel != 3'h0);

  // A level is accepted when seen on two consecutive ticks, so pulses
  // shorter than the check time never pass and two check times always do.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_r  <= '0;
      stable_r <= '0;
    end else if (sel == 3'h0) begin
      stage_r  <= pin_in;
      stable_r <= pin_in;
    end else if (tick) begin
      stage_r <= pin_in;
      for (int i = 0; i < WIDTH; i++) begin
        if (stage_r[i] == pin_in[i]) begin
          stable_r[i] <= pin_in[i]; // RL11
        end
      end
    end
  end

  assign pin_out = (sel == 3'h0) ? pin_in : stable_r; // RL10
endmodule

// file: tb/ped_src.sv
`timescale 1ns/1ps
// Signal sources on both ports; levels change just after a rising edge.
module ped_src (
  input  wire logic       core_clk,
  output logic      [7:0] port0_pins,
  output logic      [7:0] port1_pins
);
  logic [7:0] pins [2];
  assign port0_pins = pins[0];
  assign port1_pins = pins[1];
  // Drives a level on port p; with n above 0 it returns to the old level after n cycles.
  task automatic drive(input int p, input logic [7:0] v, input int n);
    logic [7:0] old;
    old = pins[p];
    @(posedge core_clk);
    pins[p] <= v;
    if (n > 0) begin
      repeat (n) @(posedge core_clk);
      pins[p] <= old;
    end
  endtask
  // Both ports idle low.
  initial begin
    pins[0] = 8'h00;
    pins[1] = 8'h00;
  end
endmodule

// file: tb/ped_top_checker.sv
`timescale 1ns/1ps
// Watches the register port and the request lines.
module ped_top_checker #(
  parameter int PIN_W = 8
) (
  input wire logic             core_clk,
  input wire logic             rst_n,
  input wire logic [PIN_W-1:0] port0_pins,
  input wire logic [PIN_W-1:0] port1_pins,
  input wire logic [15:0]      reg_addr,
  input wire logic [7:0]       reg_wdata,
  input wire logic             reg_wr,
  input wire logic             reg_rd,
  input wire logic [7:0]       reg_rdata,
  input wire logic             port0_irq,
  input wire logic             port1_irq,
  input wire logic             irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // High when the address names a register.
  logic known;
  assign known = reg_addr inside {[16'h5205:16'h5208], [16'h5215:16'h5217], 16'h5240, 16'h5241};
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read answer");
  a_unmapped_read: assert property ($past(reg_rd && !known) |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_deb_reserved: assert property ($past(reg_rd && reg_addr == 16'h5208) |-> (reg_rdata & 8'h88) == 8'h00)
    else $error("debounce reserved bits set");
  a_flag_irq_tie: assert property ($past(reg_rd && reg_addr == 16'h5217) |-> (reg_rdata != 8'h00) == $past(port1_irq))
    else $error("port1 request disagrees with flags");
  a_p1_edge_cause: assert property ($rose(port1_irq) |-> $past(port1_pins, 2) != $past(port1_pins, 3))
    else $error("port1 request without pin edge");
  a_p1_w1c_fall: assert property ($fell(port1_irq) |-> $past(reg_wr && reg_addr == 16'h5217 && reg_wdata != 8'h00))
    else $error("port1 request fell without clear");
  a_p0_w1c_fall: assert property ($fell(port0_irq) |-> $past(reg_wr && reg_addr == 16'h5207 && reg_wdata != 8'h00))
    else $error("port0 request fell without clear");
  a_irq_cause: assert property ($rose(irq) |-> $past(reg_wr) || $past(port0_irq) || $past(port1_irq))
    else $error("irq rose without cause");
  c_p0: cover property ($rose(port0_irq));
  c_p1: cover property ($rose(port1_irq));
  c_irq: cover property ($rose(irq));
endmodule
bind ped_top ped_top_checker #(.PIN_W(PIN_W)) chk_u (.core_clk(core_clk), .rst_n(rst_n),
  .port0_pins(port0_pins), .port1_pins(port1_pins), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port0_irq(port0_irq),
  .port1_irq(port1_irq), .irq(irq));

// file: tb/tb_port_edge_interrupt_debounce.sv
`timescale 1ns/1ps
// Self-checking bench: reads are noted in a queue and checked one cycle later.
module tb_port_edge_interrupt_debounce;
  logic        core_clk = 1'h0;
  logic        rst_n = 1'h0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'h0;
  logic        reg_rd = 1'h0;
  logic        rd_q = 1'h0;
  logic [7:0]  reg_rdata;
  logic [7:0]  p0, p1;
  logic        port0_irq, port1_irq, irq;
  logic [7:0]  expq [$];
  int          err_count = 0;
  int          checked = 0;
  int          cyc = 0;
  ped_src src_u (.core_clk(core_clk), .port0_pins(p0), .port1_pins(p1));
  ped_top dut_u (.core_clk(core_clk), .rst_n(rst_n), .port0_pins(p0), .port1_pins(p1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .port0_irq(port0_irq), .port1_irq(port1_irq), .irq(irq));
  // Clock of 5 ns period.
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic stop_test();
    $display("errors=%0d checks=%0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge core_clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge core_clk);
    expq.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge core_clk);
    reg_rd <= 1'h0;
  endtask
  // Read answers are compared mid-cycle, after they have settled.
  always @(posedge core_clk) rd_q <= reg_rd;
  always @(negedge core_clk) begin
    if (rd_q === 1'h1) cmp(expq.pop_front(), reg_rdata);
  end
  // Cuts a hang short.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end
  // Random edges on one port, with random polarity and enables; port 0 runs unfiltered.
  task automatic run_port(input int p);
    logic [7:0]  ed, en, nv, ov, ex;
    logic [15:0] b;
    b = p ? 16'h0010 : 16'h0000;
    repeat (4) begin
      ed = $urandom;
      en = $urandom;
      nv = $urandom;
      ov = p ? p1 : p0;
      wr(ped_pkg::ADDR_P0_IE + b, 8'h00);
      wr(ped_pkg::ADDR_P0_EDGE + b, ed);
      wr(ped_pkg::ADDR_P0_FLAGS + b, 8'hFF);
      wr(ped_pkg::ADDR_P0_IE + b, en);
      src_u.drive(p, nv, 0);
      repeat (4) @(posedge core_clk);
      ex = en & ((~ov & nv & ~ed) | (ov & ~nv & ed));
      rd(ped_pkg::ADDR_P0_FLAGS + b, ex);
      cmp({7'h00, |ex}, {7'h00, p ? port1_irq : port0_irq});
      wr(ped_pkg::ADDR_P0_FLAGS + b, ed);
      rd(ped_pkg::ADDR_P0_FLAGS + b, ex & ~ed);
    end
  endtask
  // Main sequence.
  initial begin
    logic [15:0] am [10];
    am = '{16'h5205, 16'h5206, 16'h5207, 16'h5208, 16'h5215, 16'h5216, 16'h5217,
           16'h5240, 16'h5241, 16'h5209};
    void'($urandom(32'h08bf));
    repeat (16) @(posedge core_clk);
    rst_n <= 1'h1;
    foreach (am[i]) rd(am[i], 8'h00);
    run_port(0);
    run_port(1);
    // Summary interrupt: raise, mask, clear; then edge against clear.
    wr(ped_pkg::ADDR_P1_IE, 8'h00);
    src_u.drive(1, 8'h00, 0);
    wr(ped_pkg::ADDR_P1_EDGE, 8'h00);
    wr(ped_pkg::ADDR_P1_FLAGS, 8'hFF);
    wr(ped_pkg::ADDR_IRQ_STAT, 8'h03);
    wr(ped_pkg::ADDR_IRQ_MASK, 8'h02);
    wr(ped_pkg::ADDR_P1_IE, 8'h01);
    src_u.drive(1, 8'h01, 0);
    repeat (5) @(posedge core_clk);
    cmp(8'h01, {7'h00, irq});
    rd(ped_pkg::ADDR_IRQ_STAT, 8'h02);
    wr(ped_pkg::ADDR_P1_FLAGS, 8'h01);
    // Let the clearing edge settle before looking at the request levels.
    @(negedge core_clk);
    cmp(8'h00, {7'h00, port1_irq});
    wr(ped_pkg::ADDR_IRQ_MASK, 8'h00);
    @(negedge core_clk);
    cmp(8'h00, {7'h00, irq});
    wr(ped_pkg::ADDR_IRQ_STAT, 8'h02);
    rd(ped_pkg::ADDR_IRQ_STAT, 8'h00);
    src_u.drive(1, 8'h00, 0);
    src_u.drive(1, 8'h01, 0);
    wr(ped_pkg::ADDR_P1_FLAGS, 8'h01);
    rd(ped_pkg::ADDR_P1_FLAGS, 8'h01);
    // Debounce: short pulses rejected per nibble, held level accepted.
    wr(ped_pkg::ADDR_P0_IE, 8'h00);
    src_u.drive(0, 8'h00, 0);
    wr(ped_pkg::ADDR_P0_DEB, 8'hFF);
    rd(ped_pkg::ADDR_P0_DEB, 8'h77);
    wr(ped_pkg::ADDR_P0_DEB, 8'h10);
    wr(ped_pkg::ADDR_P0_EDGE, 8'h00);
    wr(ped_pkg::ADDR_P0_FLAGS, 8'hFF);
    wr(ped_pkg::ADDR_P0_IE, 8'h11);
    src_u.drive(0, 8'h11, 200);
    repeat (600) @(posedge core_clk);
    rd(ped_pkg::ADDR_P0_FLAGS, 8'h01);
    wr(ped_pkg::ADDR_P0_IE, 8'h00);
    wr(ped_pkg::ADDR_P0_DEB, 8'h01);
    wr(ped_pkg::ADDR_P0_FLAGS, 8'hFF);
    wr(ped_pkg::ADDR_P0_IE, 8'h11);
    src_u.drive(0, 8'h11, 200);
    repeat (600) @(posedge core_clk);
    rd(ped_pkg::ADDR_P0_FLAGS, 8'h10);
    src_u.drive(0, 8'h11, 0);
    repeat (700) @(posedge core_clk);
    rd(ped_pkg::ADDR_P0_FLAGS, 8'h11);
    wr(ped_pkg::ADDR_P0_DEB, 8'h00);
    rd(ped_pkg::ADDR_P0_DEB, 8'h00);
    repeat (3) @(posedge core_clk);
    stop_test();
  end
endmodule
